// ---- hdl/tcs_cfg.svh ----
`ifndef TCS_CFG_SVH
`define TCS_CFG_SVH

// ------------------------------------------------------------
// register map
// ------------------------------------------------------------
`define TCS_STATUS_ADDR 7'h01
`define TCS_ADDR_W 7

// ------------------------------------------------------------
// status word fields
// ------------------------------------------------------------
`define TCS_PINFN_HI 15
`define TCS_PINFN_LO 14
`define TCS_ASLEEP_BIT 13
`define TCS_SELFSEQ_BIT 12
`define TCS_SETRDY_BIT 11
`define TCS_X_BIT 10
`define TCS_Y_BIT 9
`define TCS_Z1_BIT 8
`define TCS_Z2_BIT 7
`define TCS_BAT_BIT 6
`define TCS_AUX1_BIT 4
`define TCS_AUX2_BIT 3
`define TCS_TEMP1_BIT 2
`define TCS_TEMP2_BIT 1
`define TCS_PINFN_RST 2'h2
`define TCS_PINFN_PEN 2'h0
`define TCS_PINFN_DAV 2'h1

// ------------------------------------------------------------
// result channel indices
// ------------------------------------------------------------
`define TCS_NCH 9
`define TCS_CH_X 0
`define TCS_CH_Y 1
`define TCS_CH_Z1 2
`define TCS_CH_Z2 3
`define TCS_CH_BAT 4
`define TCS_CH_AUX1 5
`define TCS_CH_AUX2 6
`define TCS_CH_TEMP1 7
`define TCS_CH_TEMP2 8

`endif

// ---- hdl/tcs_pkg.sv ----
package tcs_pkg;
    typedef enum logic [2:0] {
        TCS_PIN_IDLE = 3'h1,
        TCS_PIN_PEN = 3'h2,
        TCS_PIN_DATA = 3'h4
    } tcs_pin_state_t;
    typedef logic [8:0] tcs_chan_t;
endpackage : tcs_pkg

// ---- hdl/tcs_fresh_flags.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "tcs_cfg.svh"

module tcs_fresh_flags
    import tcs_pkg::*;
#(
    parameter int NCH = `TCS_NCH
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // result events
    input wire logic [NCH-1:0] resultStored,
    input wire logic [NCH-1:0] resultReadDone,
    input wire logic bufferMode,
    // flags
    output logic [NCH-1:0] freshFlags
);
    logic [NCH-1:0] fresh_r;
    logic [NCH-1:0] fresh_nxt;

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : gen_flag
            // store wins over a same-cycle read completion
            always_comb begin
                if (resultStored[g] && !bufferMode) begin
                    fresh_nxt[g] = 1'b1;
                end else if (resultReadDone[g]) begin
                    fresh_nxt[g] = 1'b0;
                end else begin
                    fresh_nxt[g] = fresh_r[g];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fresh_r <= '0;
        end else begin
            fresh_r <= fresh_nxt;
        end
    end

    assign freshFlags = fresh_r;
endmodule : tcs_fresh_flags
`default_nettype wire

// ---- hdl/tcs_pin_ctrl.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "tcs_cfg.svh"

module tcs_pin_ctrl
    import tcs_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // sources
    input wire logic [1:0] pinFunction,
    input wire logic penTouch,
    input wire logic setComplete,
    input wire logic allRead,
    // pin
    output logic penOrReadyIrqPin_n
);
    tcs_pin_state_t state_r;
    tcs_pin_state_t state_nxt;
    logic pin_r;
    logic pin_nxt;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            TCS_PIN_IDLE: begin
                // a finished set wins over a touch, else ready mode would miss it
                if (setComplete) begin
                    state_nxt = TCS_PIN_DATA; // R02
                end else if (penTouch) begin
                    state_nxt = TCS_PIN_PEN;
                end
            end
            TCS_PIN_PEN: begin
                if (setComplete) begin
                    state_nxt = TCS_PIN_DATA;
                end else if (!penTouch) begin
                    state_nxt = TCS_PIN_IDLE;
                end
            end
            TCS_PIN_DATA: begin
                if (allRead && !setComplete) begin
                    state_nxt = penTouch ? TCS_PIN_PEN : TCS_PIN_IDLE;
                end
            end
            default: state_nxt = TCS_PIN_IDLE;
        endcase
    end

    always_comb begin
        case (pinFunction)
            `TCS_PINFN_PEN: pin_nxt = !penTouch; // R01
            `TCS_PINFN_DAV: pin_nxt = (state_nxt != TCS_PIN_DATA); // R02 R03
            // low from touch, high once the selected conversions are over
            default: pin_nxt = (state_nxt != TCS_PIN_PEN); // R04
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_r <= TCS_PIN_IDLE;
            pin_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            pin_r <= pin_nxt;
        end
    end

    assign penOrReadyIrqPin_n = pin_r;
endmodule : tcs_pin_ctrl
`default_nettype wire

// ---- hdl/tcs_status_reg.sv ----
// ------------------------------------------------------------
// Overview of operation
// (R01) pin function 00: active-low pin follows pen touch only
// (R02) pin function 01: pin goes low when a conversion set completes
// (R03) in data-ready mode the pin stays low until scanned results are read
// (R04) pin function 10/11: low on touch, high after selected conversions finish
// (R05) bits 15:14 read/write pin function, reset to 10
// (R06) bit 13 reads 1 while the converter is powered down
// (R07) bit 12 reads 1 in self-sequenced mode, 0 in host mode
// (R08) bit 11 sets when one complete conversion set finishes
// (R09) bit 11 clears only after all results of the set are read
// (R10) ready and fresh flags have no meaning in buffer mode
// (R11) X fresh flag sets on store, clears after X is read
// (R12) Y fresh flag sets on store, clears after Y is read
// (R13) Z1 fresh flag sets on store, clears after Z1 is read
// (R14) Z2 fresh flag sets on store, clears after Z2 is read
// (R15) battery fresh flag sets on store, clears after it is read
// (R16) AUX1 fresh flag sets on store, clears after it is read
// (R17) AUX2 fresh flag sets on store, clears after it is read
// (R18) TEMP1 fresh flag sets on store, clears after it is read
// (R19) TEMP2 fresh flag sets on store, clears after it is read
// (R20) in buffer mode results go to the buffer, flags tracked elsewhere
// (R21) writes to read-only and reserved bits ignored; reserved read zero
// (R22) host reads every scanned result before expecting pin or flags to clear
// ------------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none
`include "tcs_cfg.svh"

module tcs_status_reg
    import tcs_pkg::*;
#(
    parameter int ADDR_W = `TCS_ADDR_W,
    parameter int NCH = `TCS_NCH
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // decoded serial-port register access
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [15:0] regWdata,
    output logic [15:0] regRdata,
    // converter side
    input wire logic penTouch,
    input wire logic converterAsleep,
    input wire logic selfSequenced,
    input wire logic bufferMode,
    input wire logic [NCH-1:0] resultStored,
    input wire logic [NCH-1:0] resultReadDone,
    input wire logic [NCH-1:0] scanSelect,
    input wire logic setComplete,
    // pin
    output logic penOrReadyIrqPin_n,
    output logic [1:0] pinFunction
);
    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    function automatic logic hitStatus(input logic [ADDR_W-1:0] a);
        hitStatus = (a == ADDR_W'(`TCS_STATUS_ADDR));
    endfunction : hitStatus

    // ------------------------------------------------------------
    // writable pin function field
    // ------------------------------------------------------------
    logic [1:0] pinFn_r;
    logic [1:0] pinFn_nxt;

    always_comb begin
        pinFn_nxt = pinFn_r;
        if (regWrite && hitStatus(regAddr)) begin
            // only 15:14 take write data, everything else ignored
            pinFn_nxt = regWdata[`TCS_PINFN_HI:`TCS_PINFN_LO]; // R05 R21
        end
    end

    // ------------------------------------------------------------
    // set-ready tracking: pending holds results of this set not yet read
    // ------------------------------------------------------------
    logic [NCH-1:0] pending_r;
    logic [NCH-1:0] pending_nxt;
    logic setRdy_r;
    logic setRdy_nxt;
    logic allRead;

    always_comb begin
        pending_nxt = pending_r;
        // store wins over a read completion in the same cycle
        pending_nxt = (pending_r & ~resultReadDone) | (resultStored & scanSelect);
        if (bufferMode) begin
            pending_nxt = '0; // R10 R20
        end
    end

    assign allRead = (pending_nxt == '0);

    always_comb begin
        setRdy_nxt = setRdy_r;
        if (bufferMode) begin
            setRdy_nxt = 1'b0; // R10
        end else if (setComplete) begin
            setRdy_nxt = 1'b1; // R08
        end else if (setRdy_r && allRead) begin
            setRdy_nxt = 1'b0; // R09
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pinFn_r <= `TCS_PINFN_RST; // R05
            pending_r <= '0;
            setRdy_r <= 1'b0;
        end else begin
            pinFn_r <= pinFn_nxt;
            pending_r <= pending_nxt;
            setRdy_r <= setRdy_nxt;
        end
    end

    // ------------------------------------------------------------
    // per-result fresh flags
    // ------------------------------------------------------------
    logic [NCH-1:0] fresh;

    tcs_fresh_flags #(.NCH(NCH)) u_fresh (
        .clk(clk),
        .sys_rst(sys_rst),
        .resultStored(resultStored), // R11 R12 R13 R14 R15 R16 R17 R18 R19
        .resultReadDone(resultReadDone),
        .bufferMode(bufferMode),
        .freshFlags(fresh)
    );

    // ------------------------------------------------------------
    // interrupt pin
    // ------------------------------------------------------------
    tcs_pin_ctrl u_pin (
        .clk(clk),
        .sys_rst(sys_rst),
        .pinFunction(pinFn_r),
        .penTouch(penTouch),
        .setComplete(setComplete && !bufferMode),
        .allRead(allRead), // R22
        .penOrReadyIrqPin_n(penOrReadyIrqPin_n)
    );

    // ------------------------------------------------------------
    // read data, registered; reserved bits stay zero
    // ------------------------------------------------------------
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;

    always_comb begin
        rdata_nxt = rdata_r;
        if (regRead) begin
            rdata_nxt = 16'h0000; // R21
            if (hitStatus(regAddr)) begin
                rdata_nxt[`TCS_PINFN_HI:`TCS_PINFN_LO] = pinFn_r;
                rdata_nxt[`TCS_ASLEEP_BIT] = converterAsleep; // R06
                rdata_nxt[`TCS_SELFSEQ_BIT] = selfSequenced; // R07
                rdata_nxt[`TCS_SETRDY_BIT] = setRdy_r;
                rdata_nxt[`TCS_X_BIT] = fresh[`TCS_CH_X];
                rdata_nxt[`TCS_Y_BIT] = fresh[`TCS_CH_Y];
                rdata_nxt[`TCS_Z1_BIT] = fresh[`TCS_CH_Z1];
                rdata_nxt[`TCS_Z2_BIT] = fresh[`TCS_CH_Z2];
                rdata_nxt[`TCS_BAT_BIT] = fresh[`TCS_CH_BAT];
                rdata_nxt[`TCS_AUX1_BIT] = fresh[`TCS_CH_AUX1];
                rdata_nxt[`TCS_AUX2_BIT] = fresh[`TCS_CH_AUX2];
                rdata_nxt[`TCS_TEMP1_BIT] = fresh[`TCS_CH_TEMP1];
                rdata_nxt[`TCS_TEMP2_BIT] = fresh[`TCS_CH_TEMP2];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata_r <= 16'h0000;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign regRdata = rdata_r;
    assign pinFunction = pinFn_r;
endmodule : tcs_status_reg
`default_nettype wire

// ---- test/tcs_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "tcs_cfg.svh"

module tcs_host_model (
    // clock
    input wire logic clk,
    // register port
    output logic [`TCS_ADDR_W-1:0] regAddr,
    output logic regWrite,
    output logic regRead,
    output logic [15:0] regWdata,
    input wire logic [15:0] regRdata
);
    // ------------------------------------------------------------
    // serial-port accesses
    // ------------------------------------------------------------
    initial begin
        regAddr = 7'h00;
        regWrite = 1'b0;
        regRead = 1'b0;
        regWdata = 16'h0000;
    end

    task automatic wr(input logic [15:0] d);
        @(posedge clk);
        regAddr <= `TCS_STATUS_ADDR;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
        // stale data is not left on the bus after the access
        regWdata <= ~d;
    endtask : wr

    task automatic rd(input logic [`TCS_ADDR_W-1:0] a, output logic [15:0] d);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1 d = regRdata;
    endtask : rd
endmodule : tcs_host_model
`default_nettype wire

// ---- test/tcs_status_reg_properties.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "tcs_cfg.svh"

module tcs_status_checker
    import tcs_pkg::*;
#(
    parameter int ADDR_W = `TCS_ADDR_W,
    parameter int NCH = `TCS_NCH
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // register access
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [15:0] regWdata,
    input wire logic [15:0] regRdata,
    // converter side
    input wire logic penTouch,
    input wire logic converterAsleep,
    input wire logic selfSequenced,
    input wire logic bufferMode,
    input wire logic [NCH-1:0] resultStored,
    input wire logic [NCH-1:0] resultReadDone,
    input wire logic [NCH-1:0] scanSelect,
    input wire logic setComplete,
    // pin
    input wire logic penOrReadyIrqPin_n,
    input wire logic [1:0] pinFunction
);
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    wire logic statusHit = regAddr == ADDR_W'(`TCS_STATUS_ADDR);
    sequence statusRd;
        regRead && statusHit;
    endsequence

    a_reset_defaults: assert property (disable iff (1'b0) sys_rst |=> penOrReadyIrqPin_n
        && pinFunction == 2'h2 && regRdata == 16'h0000) else $error("reset values wrong");
    a_pinfn_write: assert property (regWrite && statusHit |=>
        pinFunction == $past(regWdata[15:14])) else $error("pin function not written");
    a_status_read: assert property (statusRd |=> regRdata[15:12] == {$past(pinFunction),
        $past(converterAsleep), $past(selfSequenced)} && regRdata[5] == 1'b0 && regRdata[0] == 1'b0)
        else $error("status read wrong");
    a_unmapped_zero: assert property (regRead && !statusHit |=> regRdata == 16'h0000)
        else $error("unmapped read not zero");
    a_pen_only: assert property (pinFunction == 2'h0 |=> penOrReadyIrqPin_n == !$past(penTouch))
        else $error("pen pin wrong");
    a_ready_low: assert property (pinFunction == 2'h1 && setComplete && !bufferMode |=>
        !penOrReadyIrqPin_n) else $error("ready pin not low");
    a_ready_holds: assert property (pinFunction == 2'h1 && !penOrReadyIrqPin_n && !bufferMode
        && !regWrite && resultReadDone == '0 |=> !penOrReadyIrqPin_n) else $error("ready pin rose");
    a_fresh_x: assert property (resultStored[0] && !bufferMode ##1 statusRd |=> regRdata[10])
        else $error("x fresh flag missing");
    a_set_ready: assert property (setComplete && !bufferMode ##1 statusRd |=> regRdata[11])
        else $error("set ready missing");
    a_buffer_quiet: assert property (bufferMode ##1 (bufferMode && regRead && statusHit) |=>
        !regRdata[11])
        else $error("set ready in buffer mode");

    c_status_read: cover property (statusRd);
    c_ready_pin: cover property (pinFunction == 2'h1 && !penOrReadyIrqPin_n);
    c_pen_pin: cover property (pinFunction == 2'h0 && penTouch);
endmodule : tcs_status_checker

bind tcs_status_reg tcs_status_checker #(.ADDR_W(ADDR_W), .NCH(NCH)) chk (.*);
`default_nettype wire

// ---- test/touch_adc_status_and_irq_pin_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "tcs_cfg.svh"

module touch_adc_status_and_irq_pin_tb;
    import tcs_pkg::*;
    logic clk, sys_rst, penTouch, converterAsleep, selfSequenced, bufferMode, setComplete;
    tcs_chan_t resultStored, resultReadDone, scanSelect;
    logic [`TCS_ADDR_W-1:0] regAddr;
    logic regWrite, regRead, penOrReadyIrqPin_n;
    logic [15:0] regWdata, regRdata, got;
    logic [1:0] pinFunction;
    int miscompares = 0;
    int checked = 0;
    int bitPos [9] = '{10, 9, 8, 7, 6, 4, 3, 2, 1};

    tcs_status_reg uut (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrite(regWrite),
        .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata), .penTouch(penTouch),
        .converterAsleep(converterAsleep), .selfSequenced(selfSequenced),
        .bufferMode(bufferMode), .resultStored(resultStored), .resultReadDone(resultReadDone),
        .scanSelect(scanSelect), .setComplete(setComplete),
        .penOrReadyIrqPin_n(penOrReadyIrqPin_n), .pinFunction(pinFunction));
    tcs_host_model host (.clk(clk), .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
        .regWdata(regWdata), .regRdata(regRdata));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t ns: got %h want %h", $time, seen, exp);
        end
    endtask : check

    task automatic chk_rd(input logic [15:0] exp);
        host.rd(`TCS_STATUS_ADDR, got);
        check(got, exp);
    endtask : chk_rd

    task automatic ev(input tcs_chan_t st, input tcs_chan_t dn, input logic sc);
        @(posedge clk);
        resultStored <= st;
        resultReadDone <= dn;
        setComplete <= sc;
        @(posedge clk);
        resultStored <= '0;
        resultReadDone <= '0;
        setComplete <= 1'b0;
        #1;
    endtask : ev

    task automatic touch(input logic v);
        @(posedge clk);
        penTouch <= v;
        @(posedge clk);
        #1;
    endtask : touch

    task automatic give_verdict;
        $display("checked %0d, miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : give_verdict

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        give_verdict();
    end

    initial begin
        {sys_rst, penTouch, converterAsleep, selfSequenced, bufferMode, setComplete} = 6'h20;
        {resultStored, resultReadDone} = '0;
        scanSelect = 9'h003;
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        chk_rd(16'h8000);
        host.wr(16'hFFFF);
        @(posedge clk);
        {converterAsleep, selfSequenced} <= 2'h3;
        check({14'h0000, pinFunction}, 16'h0003);
        chk_rd(16'hF000);
        host.wr(16'h0000);
        {converterAsleep, selfSequenced} <= 2'h0;
        touch(1'b1);
        check({15'h0000, penOrReadyIrqPin_n}, 16'h0000);
        touch(1'b0);
        check({15'h0000, penOrReadyIrqPin_n}, 16'h0001);
        $display("register and pen tests done");
        for (int i = 0; i < 9; i++) begin
            ev(9'h001 << i, '0, 1'b0);
            chk_rd(16'h0001 << bitPos[i]);
            ev('0, 9'h001 << i, 1'b0);
            chk_rd(16'h0000);
        end
        $display("fresh flag tests done");
        host.wr(16'h4000);
        ev(9'h003, '0, 1'b0);
        ev('0, '0, 1'b1);
        check({15'h0000, penOrReadyIrqPin_n}, 16'h0000);
        chk_rd(16'h4E00);
        ev('0, 9'h001, 1'b0);
        check({15'h0000, penOrReadyIrqPin_n}, 16'h0000);
        chk_rd(16'h4A00);
        ev('0, 9'h002, 1'b0);
        check({15'h0000, penOrReadyIrqPin_n}, 16'h0001);
        chk_rd(16'h4000);
        $display("data ready tests done");
        host.wr(16'h8000);
        scanSelect <= 9'h001;
        touch(1'b1);
        check({15'h0000, penOrReadyIrqPin_n}, 16'h0000);
        ev(9'h001, '0, 1'b0);
        ev('0, '0, 1'b1);
        check({15'h0000, penOrReadyIrqPin_n}, 16'h0001);
        chk_rd(16'h8C00);
        ev('0, 9'h001, 1'b0);
        check({15'h0000, penOrReadyIrqPin_n}, 16'h0000);
        touch(1'b0);
        $display("combined pin tests done");
        @(posedge clk);
        bufferMode <= 1'b1;
        ev(9'h001, '0, 1'b1);
        chk_rd(16'h8000);
        host.rd(7'h02, got);
        check(got, 16'h0000);
        $display("buffer and unmapped tests done");
        give_verdict();
    end
endmodule : touch_adc_status_and_irq_pin_tb
`default_nettype wire
